// >>> shared/arzc_pkg.sv
// Package for the reclose sequencer with zone coordination.
// Assumes a 125 MHz core clock; timer settings arrive in milliseconds.
package arzc_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam int unsigned BRK_SUP_MS    = 200;
  localparam int unsigned TMR_W         = 16;
  localparam int unsigned SHOT_W        = 3;
  localparam int unsigned MAX_SHOTS     = 6;
  localparam int unsigned MS_CNT_W      = 17;
  localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);
  localparam logic [TMR_W-1:0] BRK_SUP_T  = TMR_W'(BRK_SUP_MS);
  localparam logic [SHOT_W-1:0] SHOT_ZERO = 3'h0;
  localparam logic [SHOT_W-1:0] SHOT_ONE  = 3'h1;
  localparam logic [TMR_W-1:0] TMR_ZERO   = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE    = 16'h0001;

  typedef enum logic [3:0] {
    ARZC_STANDBY  = 4'h0,
    ARZC_MC_BLOCK = 4'h1,
    ARZC_READY    = 4'h2,
    ARZC_RUNNING  = 4'h3,
    ARZC_WAIT_OPEN= 4'h4,
    ARZC_DEAD     = 4'h5,
    ARZC_RECLOSE  = 4'h6,
    ARZC_RUN2RDY  = 4'h7,
    ARZC_LOCKOUT  = 4'h8
  } arzc_state_t;
endpackage : arzc_pkg

// >>> shared/arzc_tmr_if.sv
// Interface between the sequencer and its millisecond timer.
// Assumes both ends on core_clk.
`timescale 1ns/10ps
`default_nettype none
interface arzc_tmr_if;
  import arzc_pkg::*;
  logic             start;
  logic [TMR_W-1:0] load_ms;
  logic             running;
  logic             expired;
  modport ctl (output start, output load_ms, input running, input expired);
  modport tmr (input start, input load_ms, output running, output expired);
endinterface : arzc_tmr_if
`default_nettype wire

// >>> src/arzc_ms_timer.sv
// Millisecond down-counter; start reloads, expired pulses one cycle at end.
// Assumes start comes from core_clk logic; a zero load expires after one tick.
`timescale 1ns/10ps
`default_nettype none
module arzc_ms_timer #(
  parameter int unsigned TICK_CYC = arzc_pkg::MS_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  arzc_tmr_if.tmr   t
);
  import arzc_pkg::*;
  // Prescaler width limits the tick to 2**MS_CNT_W cycles
  localparam logic [MS_CNT_W-1:0] PRE_LAST = MS_CNT_W'(TICK_CYC - 1);
  logic [MS_CNT_W-1:0] pre_ff,  nxt_pre;
  logic [TMR_W-1:0]    cnt_ff,  nxt_cnt;
  logic                run_ff,  nxt_run;
  logic                exp_ff,  nxt_exp;

  always_comb begin
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_exp = 1'b0;
    if (t.start) begin
      nxt_pre = PRE_LAST;
      nxt_cnt = t.load_ms;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (pre_ff != '0) begin
        nxt_pre = pre_ff - 1'b1;
      end else begin
        nxt_pre = PRE_LAST;
        if (cnt_ff <= TMR_ONE) begin
          nxt_cnt = TMR_ZERO;
          nxt_run = 1'b0;
          nxt_exp = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - TMR_ONE;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pre_ff <= '0;
      cnt_ff <= TMR_ZERO;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  assign t.running = run_ff;
  assign t.expired = exp_ff;
endmodule : arzc_ms_timer
`default_nettype wire

// >>> src/arzc_seq.sv
// Reclose sequencer with manual-close blocking and zone coordination.
// Assumes breaker and protection inputs come from pins (synchronised here).
// What this block does
// - Trip during manual-close blocking opens breaker at once; blocking timer keeps running.
// - At blocking timer end, breaker open means standby, never lockout.
// - Zone coordination enable selects a virtual cycle following a downstream recloser.
// - Zone coordination uses the same shot count, dead times, initiates and timers.
// - In zone coordination the dead timer starts without a local breaker trip.
// - In zone coordination the dead timer starts on overcurrent pickup dropout.
// - Zone coordination dead end increments shot, starts run-to-ready, no close command.
// - Shot number output selects thresholds and curves for renewed pickup.
// - Transient fault in zone coordination resets normally after run-to-ready expiry.
// - Manual close from standby starts blocking timer; ready only if still closed.
// - After trip, breaker must open within 200 ms before dead timer starts.
// - Normal reclosing increments shot counter in the same cycle as the close command.
// - No fault during run-to-ready sets success flag; returns to ready if breaker closed, else standby.
`timescale 1ns/10ps
`default_nettype none
module arzc_seq #(
  parameter int unsigned TICK_CYC = arzc_pkg::MS_CYCLES
) (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           enable,
  input  wire logic                           zone_coord_en,
  input  wire logic                           cb_closed,
  input  wire logic                           prot_pickup,
  input  wire logic                           prot_trip,
  input  wire logic                           lockout_reset,
  input  wire logic [arzc_pkg::SHOT_W-1:0]    max_shots,
  input  wire logic [arzc_pkg::TMR_W-1:0]     mc_block_ms,
  input  wire logic [arzc_pkg::TMR_W-1:0]     dead_ms [arzc_pkg::MAX_SHOTS],
  input  wire logic [arzc_pkg::TMR_W-1:0]     fault_ms,
  input  wire logic [arzc_pkg::TMR_W-1:0]     close_sup_ms,
  input  wire logic [arzc_pkg::TMR_W-1:0]     run2rdy_ms,
  output var  logic                           trip_cmd,
  output var  logic                           close_cmd,
  output var  logic [arzc_pkg::SHOT_W-1:0]    shot_num,
  output var  logic [3:0]                     seq_state,
  output var  logic                           success,
  output var  logic                           failed,
  output var  logic                           lockout
);
  import arzc_pkg::*;

  // Two-flop synchronisers for pin inputs
  logic [3:0] s1_ff, s2_ff;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
    end else begin
      s1_ff <= {lockout_reset, prot_trip, prot_pickup, cb_closed};
      s2_ff <= s1_ff;
    end
  end
  wire logic closed  = s2_ff[0];
  wire logic pickup  = s2_ff[1];
  wire logic trip    = s2_ff[2];
  wire logic lo_rst  = s2_ff[3];

  // Blocking timer is its own instance so trips never disturb it
  arzc_tmr_if mc_t ();
  arzc_tmr_if sq_t ();
  arzc_ms_timer #(.TICK_CYC(TICK_CYC)) u_mc (.core_clk(core_clk), .nrst(nrst), .t(mc_t.tmr));
  arzc_ms_timer #(.TICK_CYC(TICK_CYC)) u_sq (.core_clk(core_clk), .nrst(nrst), .t(sq_t.tmr));

  function automatic logic [TMR_W-1:0] dead_for(input logic [SHOT_W-1:0] s);
    dead_for = (s < SHOT_W'(MAX_SHOTS)) ? dead_ms[s] : dead_ms[MAX_SHOTS-1];
  endfunction : dead_for

  arzc_state_t      st_ff, nxt_st;
  logic [SHOT_W-1:0] shot_ff, nxt_shot;
  logic             trip_ff, nxt_trip;
  logic             close_ff, nxt_close;
  logic             succ_ff, nxt_succ;
  logic             fail_ff, nxt_fail;
  logic             lock_ff, nxt_lock;
  logic             pick_d_ff;
  logic             mc_start, sq_start;
  logic [TMR_W-1:0] sq_load;

  wire logic pick_drop = pick_d_ff & ~pickup;

  always_comb begin
    nxt_st    = st_ff;
    nxt_shot  = shot_ff;
    nxt_trip  = trip;
    nxt_close = 1'b0;
    nxt_succ  = succ_ff;
    nxt_fail  = fail_ff;
    mc_start  = 1'b0;
    sq_start  = 1'b0;
    sq_load   = fault_ms;
    unique case (st_ff)
      ARZC_STANDBY: begin
        if (enable && closed) begin
          mc_start = 1'b1;
          nxt_st   = ARZC_MC_BLOCK;
        end
      end
      ARZC_MC_BLOCK: begin
        // Trips are not looked at here: the timer runs on regardless
        if (mc_t.expired) begin
          nxt_st = closed ? ARZC_READY : ARZC_STANDBY;
        end
      end
      ARZC_READY: begin
        if (!closed) begin
          nxt_st = ARZC_STANDBY;
        end else if (pickup || trip) begin
          sq_start = 1'b1;
          nxt_succ = 1'b0;
          nxt_fail = 1'b0;
          nxt_st   = ARZC_RUNNING;
        end
      end
      ARZC_RUNNING: begin
        if (zone_coord_en && pick_drop && !trip) begin
          sq_start = 1'b1;
          sq_load  = dead_for(shot_ff);
          nxt_st   = ARZC_DEAD;
        end else if (trip) begin
          sq_start = 1'b1;
          sq_load  = BRK_SUP_T;
          nxt_st   = ARZC_WAIT_OPEN;
        end else if (sq_t.expired) begin
          nxt_fail = 1'b1;
          nxt_shot = SHOT_ZERO;
          nxt_st   = ARZC_LOCKOUT;
        end
      end
      ARZC_WAIT_OPEN: begin
        if (!closed) begin
          sq_start = 1'b1;
          sq_load  = dead_for(shot_ff);
          nxt_st   = ARZC_DEAD;
        end else if (sq_t.expired) begin
          nxt_fail = 1'b1;
          nxt_shot = SHOT_ZERO;
          nxt_st   = ARZC_LOCKOUT;
        end
      end
      ARZC_DEAD: begin
        if (sq_t.expired) begin
          nxt_shot = shot_ff + SHOT_ONE;
          sq_start = 1'b1;
          if (zone_coord_en) begin
            sq_load = run2rdy_ms;
            nxt_st  = ARZC_RUN2RDY;
          end else if (!closed && !pickup && !trip) begin
            sq_load   = close_sup_ms;
            nxt_close = 1'b1;
            nxt_st    = ARZC_RECLOSE;
          end else begin
            nxt_fail = 1'b1;
            nxt_shot = SHOT_ZERO;
            nxt_st   = ARZC_LOCKOUT;
          end
        end
      end
      ARZC_RECLOSE: begin
        nxt_close = ~closed;
        if (closed) begin
          sq_start  = 1'b1;
          sq_load   = run2rdy_ms;
          nxt_close = 1'b0;
          nxt_st    = ARZC_RUN2RDY;
        end else if (sq_t.expired) begin
          nxt_close = 1'b0;
          nxt_fail  = 1'b1;
          nxt_shot  = SHOT_ZERO;
          nxt_st    = ARZC_LOCKOUT;
        end
      end
      ARZC_RUN2RDY: begin
        if (pickup || trip) begin
          if (shot_ff >= max_shots) begin
            nxt_fail = 1'b1;
            nxt_shot = SHOT_ZERO;
            nxt_st   = ARZC_LOCKOUT;
          end else begin
            sq_start = 1'b1;
            sq_load  = fault_ms;
            nxt_st   = ARZC_RUNNING;
          end
        end else if (sq_t.expired) begin
          nxt_succ = 1'b1;
          nxt_shot = SHOT_ZERO;
          nxt_st   = closed ? ARZC_READY : ARZC_STANDBY;
        end
      end
      ARZC_LOCKOUT: begin
        if (lo_rst) begin
          nxt_st = closed ? ARZC_READY : ARZC_STANDBY;
        end
      end
      default: begin
        nxt_shot = SHOT_ZERO;
        nxt_st   = ARZC_STANDBY;
      end
    endcase
    if (!enable) begin
      nxt_st    = ARZC_STANDBY;
      nxt_shot  = SHOT_ZERO;
      nxt_close = 1'b0;
    end
    // Registered copy so the flag comes straight from a flop
    nxt_lock = (nxt_st == ARZC_LOCKOUT);
  end

  assign mc_t.start   = mc_start;
  assign mc_t.load_ms = mc_block_ms;
  assign sq_t.start   = sq_start;
  assign sq_t.load_ms = sq_load;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff     <= ARZC_STANDBY;
      shot_ff   <= SHOT_ZERO;
      trip_ff   <= 1'b0;
      close_ff  <= 1'b0;
      succ_ff   <= 1'b0;
      fail_ff   <= 1'b0;
      lock_ff   <= 1'b0;
      pick_d_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      shot_ff   <= nxt_shot;
      trip_ff   <= nxt_trip;
      close_ff  <= nxt_close;
      succ_ff   <= nxt_succ;
      fail_ff   <= nxt_fail;
      lock_ff   <= nxt_lock;
      pick_d_ff <= pickup;
    end
  end

  assign trip_cmd  = trip_ff;
  assign close_cmd = close_ff;
  assign shot_num  = shot_ff;
  assign seq_state = st_ff;
  assign success   = succ_ff;
  assign failed    = fail_ff;
  assign lockout   = lock_ff;
endmodule : arzc_seq
`default_nettype wire

// >>> tb/arzc_brk_model.sv
// Breaker model: opens on trip command, closes on close command or by hand.
// Assumes commands come from the sequencer on core_clk.
`timescale 1ns/10ps
`default_nettype none
module arzc_brk_model (
  input  wire logic core_clk,
  input  wire logic trip_cmd,
  input  wire logic close_cmd,
  input  wire logic man_close,
  input  wire logic slow,
  output var  logic cb_closed
);
  int lag;
  initial begin
    cb_closed = 1'b0;
    lag = 0;
  end
  // Contacts move some cycles after the coil; slow mode stretches travel
  always @(posedge core_clk) begin
    if (man_close) cb_closed <= 1'b1;
    else if ((trip_cmd && cb_closed) || (close_cmd && !cb_closed)) begin
      lag <= lag + 1;
      if (lag >= (slow ? 40 : 2)) begin
        cb_closed <= !cb_closed;
        lag <= 0;
      end
    end else lag <= 0;
  end
endmodule : arzc_brk_model
`default_nettype wire

// >>> tb/arzc_seq_assertions.sv
// Checker on the sequencer top ports.
// Assumes pins reach the state register three cycles after they change.
`timescale 1ns/10ps
`default_nettype none
module arzc_seq_chk import arzc_pkg::*; (
  input wire logic                        core_clk,
  input wire logic                        nrst,
  input wire logic                        zone_coord_en,
  input wire logic                        cb_closed,
  input wire logic                        prot_trip,
  input wire logic                        trip_cmd,
  input wire logic                        close_cmd,
  input wire logic [arzc_pkg::SHOT_W-1:0] shot_num,
  input wire logic [arzc_pkg::SHOT_W-1:0] max_shots,
  input wire logic [3:0]                  seq_state,
  input wire logic                        success,
  input wire logic                        lockout
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_trip_follow: assert property (trip_cmd == $past(prot_trip, 3))
    else $error("trip command lag wrong");
  chk_block_stay: assert property (seq_state == ARZC_MC_BLOCK |=>
    seq_state inside {ARZC_STANDBY, ARZC_MC_BLOCK, ARZC_READY}) else $error("block exit wrong");
  chk_block_ready: assert property ($past(seq_state) == ARZC_MC_BLOCK &&
    seq_state == ARZC_READY |-> $past(cb_closed, 3)) else $error("ready with breaker open");
  chk_zone_noclose: assert property (zone_coord_en |-> !close_cmd)
    else $error("close command in zone mode");
  chk_shot_step: assert property ($past(seq_state) == ARZC_DEAD &&
    seq_state inside {ARZC_RECLOSE, ARZC_RUN2RDY} |-> shot_num == $past(shot_num) + 3'h1)
    else $error("shot not incremented");
  chk_shot_clear: assert property (seq_state inside
    {ARZC_STANDBY, ARZC_READY, ARZC_LOCKOUT} |-> shot_num == SHOT_ZERO) else $error("shot kept");
  chk_lock_flag: assert property (lockout == (seq_state == ARZC_LOCKOUT))
    else $error("lockout flag wrong");
  chk_max_rerun: assert property ($past(seq_state) == ARZC_RUN2RDY &&
    seq_state == ARZC_RUNNING |-> $past(shot_num) < $past(max_shots))
    else $error("rerun past max shots");
  chk_run_dead: assert property ($past(seq_state) == ARZC_RUNNING &&
    seq_state == ARZC_DEAD |-> $past(zone_coord_en)) else $error("dead start without zone");
  chk_rdy_success: assert property ($past(seq_state) == ARZC_RUN2RDY &&
    seq_state == ARZC_READY |-> success) else $error("success flag missing");
  cov_zone_shot: cover property ($past(seq_state) == ARZC_DEAD && seq_state == ARZC_RUN2RDY);
  cov_lockout: cover property ($rose(lockout));
  cov_success: cover property ($rose(success));
endmodule : arzc_seq_chk
`default_nettype wire
bind arzc_seq arzc_seq_chk u_chk (.core_clk, .nrst, .zone_coord_en, .cb_closed, .prot_trip,
  .trip_cmd, .close_cmd, .shot_num, .max_shots, .seq_state, .success, .lockout);

// >>> tb/tb_autoreclose_zone_coordination.sv
// Bench for the reclose sequencer with a breaker model on its far side.
// Assumes a shortened millisecond tick, set below, to keep the run short.
`timescale 1ns/10ps
`default_nettype none
module tb_autoreclose_zone_coordination;
  import arzc_pkg::*;
  logic core_clk, nrst, enable, zone_coord_en, cb_closed, prot_pickup, prot_trip;
  logic lockout_reset, trip_cmd, close_cmd, success, failed, lockout, man_close, slow;
  logic [SHOT_W-1:0] max_shots, shot_num;
  logic [TMR_W-1:0]  mc_block_ms, fault_ms, close_sup_ms, run2rdy_ms;
  logic [TMR_W-1:0]  dead_ms [MAX_SHOTS];
  logic [3:0]        seq_state;
  int                fails, cmp_count, cyc;
  // Short tick: each ms timer run takes a few hundred cycles, logic unchanged
  localparam int unsigned TB_TICK = 250;

  arzc_seq #(.TICK_CYC(TB_TICK)) DUT (.core_clk, .nrst, .enable, .zone_coord_en,
    .cb_closed, .prot_pickup,
    .prot_trip, .lockout_reset, .max_shots, .mc_block_ms, .dead_ms, .fault_ms, .close_sup_ms,
    .run2rdy_ms, .trip_cmd, .close_cmd, .shot_num, .seq_state, .success, .failed, .lockout);
  arzc_brk_model brk (.core_clk, .trip_cmd, .close_cmd, .man_close, .slow, .cb_closed);

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wait_st(input logic [3:0] s, input int lim);
    int n;
    n = 0;
    while (seq_state !== s && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(seq_state, s, "state");
  endtask : wait_st

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // About ten short-tick timer runs, with wide margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20_000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end

  initial begin
    {nrst, zone_coord_en, prot_pickup, prot_trip, lockout_reset, man_close, slow} = '0;
    {enable, fails, cmp_count, cyc} = '0;
    enable = 1'b1;
    max_shots = 3'h2;
    {mc_block_ms, run2rdy_ms, fault_ms, close_sup_ms} = {16'h0001, 16'h0001, 16'h0064, 16'h0064};
    foreach (dead_ms[i]) dead_ms[i] = 16'h0001;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk(seq_state, ARZC_STANDBY, "reset state");
    chk({3'h0, lockout}, 4'h0, "reset lockout");
    @(posedge core_clk) man_close <= 1'b1;
    @(posedge core_clk) man_close <= 1'b0;
    wait_st(ARZC_MC_BLOCK, 20);
    @(posedge core_clk) prot_trip <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk({3'h0, trip_cmd}, 4'h1, "trip");
    chk({3'h0, cb_closed}, 4'h0, "open");
    chk(seq_state, ARZC_MC_BLOCK, "block kept");
    @(posedge core_clk) prot_trip <= 1'b0;
    wait_st(ARZC_STANDBY, 130_000);
    chk({3'h0, lockout}, 4'h0, "no lockout");
    $display("End of trip during blocking");
    @(posedge core_clk) man_close <= 1'b1;
    @(posedge core_clk) man_close <= 1'b0;
    wait_st(ARZC_MC_BLOCK, 20);
    wait_st(ARZC_READY, 130_000);
    $display("End of manual close");
    @(posedge core_clk) {zone_coord_en, prot_pickup} <= 2'b11;
    for (int s = 1; s <= 2; s++) begin
      wait_st(ARZC_RUNNING, 20);
      chk({1'b0, shot_num}, 4'(s - 1), "shot at pickup");
      @(posedge core_clk) prot_pickup <= 1'b0;
      wait_st(ARZC_DEAD, 20);
      chk({3'h0, cb_closed}, 4'h1, "local breaker closed");
      wait_st(ARZC_RUN2RDY, 130_000);
      chk({1'b0, shot_num}, 4'(s), "virtual shot");
      chk({3'h0, close_cmd}, 4'h0, "no close");
      @(posedge core_clk) prot_pickup <= 1'b1;
    end
    wait_st(ARZC_LOCKOUT, 20);
    chk({3'h0, failed}, 4'h1, "failed flag");
    chk({1'b0, shot_num}, 4'h0, "shot cleared");
    @(posedge core_clk) {prot_pickup, lockout_reset} <= 2'b01;
    wait_st(ARZC_READY, 20);
    @(posedge core_clk) {prot_pickup, lockout_reset} <= 2'b10;
    wait_st(ARZC_RUNNING, 20);
    @(posedge core_clk) prot_pickup <= 1'b0;
    wait_st(ARZC_DEAD, 20);
    wait_st(ARZC_RUN2RDY, 1_000);
    wait_st(ARZC_READY, 1_000);
    chk({3'h0, success}, 4'h1, "zone transient success");
    chk({1'b0, shot_num}, 4'h0, "zone shot cleared");
    @(posedge core_clk) {zone_coord_en, lockout_reset, slow, prot_trip} <= 4'b0011;
    $display("End of zone coordination");
    wait_st(ARZC_DEAD, 300);
    @(posedge core_clk) prot_trip <= 1'b0;
    wait_st(ARZC_RECLOSE, 130_000);
    chk({1'b0, shot_num}, 4'h1, "shot before close");
    chk({3'h0, close_cmd}, 4'h1, "close command");
    wait_st(ARZC_RUN2RDY, 300);
    wait_st(ARZC_READY, 130_000);
    chk({3'h0, success}, 4'h1, "success flag");
    chk({1'b0, shot_num}, 4'h0, "shot cleared");
    $display("End of normal reclose");
    conclude();
  end
endmodule : tb_autoreclose_zone_coordination
`default_nettype wire
